//--- dv/spi_master_model.sv
`timescale 1ns/100ps

// Link master; its clock stands low outside frames
module spi_master_model (
  input  wire logic clk,
  input  wire logic so_w,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // One frame, 80 ns link period; so taken late in high phase for sync lag
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = '0;
    @(negedge clk);
    cs_n = 1'b0;
    si   = tx[n-1];
    repeat (8) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      rx   = {rx[30:0], so_w};
      sclk = 1'b0;
      if (i > 0) begin
        si = tx[i-1];
      end
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    si   = ~si; // Idle input shows no stale bit
    // Supply faults do not gate the latch, so no word is discarded for supply
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : spi_master_model

//--- dv/spi_status_readback_sva.sv
`timescale 1ns/100ps

module spi_status_readback_sva (
  input wire logic                                     clk,
  input wire logic                                     arst_n,
  input wire logic                                     sclk,
  input wire logic                                     cs_n,
  input wire logic                                     so,
  input wire logic                                     so_oe,
  input wire logic                                     supply_low_fault,
  input wire logic                                     supply_high_fault,
  input wire logic [spi_status_pkg::N_OUT-1:0]         open_load_on_fault,
  input wire logic [spi_status_pkg::N_OUT-1:0]         open_load_off_fault,
  input wire logic [spi_status_pkg::N_OUT-1:0]         short_to_battery_fault,
  input wire logic [spi_status_pkg::N_OUT-1:0]         thermal_fault,
  input wire logic [spi_status_pkg::N_OUT-1:0]         severe_short_fault,
  input wire logic [spi_status_pkg::N_OUT-1:0]         overcurrent_fault,
  input wire logic                                     fault_status_pin_n,
  input wire logic [spi_status_pkg::N_OUT-1:0]
                   [spi_status_pkg::DUTY_W-1:0]        duty_register,
  input wire logic [spi_status_pkg::N_OUT-1:0]
                   [spi_status_pkg::SWCFG_W-1:0]       switching_config,
  input wire logic [spi_status_pkg::N_OUT-1:0]
                   [spi_status_pkg::FLTCFG_W-1:0]      fault_config,
  input wire logic [spi_status_pkg::N_OUT-1:0]
                   [spi_status_pkg::OCP_W-1:0]         overcurrent_profile,
  input wire logic [spi_status_pkg::GCR_W-1:0]         global_config,
  input wire logic                                     watchdog_toggle_bit
);
  import spi_status_pkg::*;
  logic       sclk_p_q;
  logic       cs_p_q;
  logic [3:0] edge_cnt_q;
  logic [3:0] rise_cnt_q;
  logic       live_fault;

  // Age of the last clock fall or select, and of the last deselect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_p_q   <= 1'b0;
      cs_p_q     <= 1'b1;
      edge_cnt_q <= 4'hF;
      rise_cnt_q <= 4'hF;
    end else begin
      sclk_p_q   <= sclk;
      cs_p_q     <= cs_n;
      edge_cnt_q <= ((sclk_p_q && !sclk) || (cs_p_q && !cs_n)) ? 4'h0 :
                    (edge_cnt_q == 4'hF) ? 4'hF : edge_cnt_q + 4'h1;
      rise_cnt_q <= (!cs_p_q && cs_n) ? 4'h0 :
                    (rise_cnt_q == 4'hF) ? 4'hF : rise_cnt_q + 4'h1;
    end
  end

  // Any live fault of any output
  assign live_fault = supply_low_fault | supply_high_fault |
                      (|open_load_on_fault) | (|open_load_off_fault) |
                      (|short_to_battery_fault) | (|thermal_fault) |
                      (|severe_short_fault) | (|overcurrent_fault);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Frame phases seen at the pins
  sequence sel_start_s; $fell(cs_n); endsequence
  sequence frame_end_s; $rose(cs_n); endsequence
  sequence cs_idle_s; cs_n [*8]; endsequence
  sequence cs_busy_s; !cs_n [*8]; endsequence

  oe_start_a: assert property (sel_start_s |-> ##[2:6] so_oe)
    else $error("serial output not enabled after select");
  oe_release_a: assert property (frame_end_s |-> ##[2:6] !so_oe)
    else $error("serial output not released after deselect");
  idle_quiet_a: assert property (cs_idle_s |-> !so_oe)
    else $error("serial output driven while deselected");
  busy_drive_a: assert property (cs_busy_s |-> so_oe)
    else $error("serial output not driven while selected");
  so_timing_a: assert property (so_oe && $past(so_oe) && $changed(so)
    |-> edge_cnt_q inside {[1:6]})
    else $error("serial output moved away from a clock fall");
  wd_update_a: assert property ($changed(watchdog_toggle_bit)
    |-> rise_cnt_q <= 4'h6)
    else $error("watchdog echo changed outside frame end");
  cfg_update_a: assert property ($changed({duty_register, switching_config,
    fault_config, overcurrent_profile, global_config})
    |-> rise_cnt_q <= 4'h6)
    else $error("register changed outside frame end");
  fault_pin_a: assert property (live_fault |=> !fault_status_pin_n)
    else $error("fault pin idle during live fault");
endmodule : spi_status_readback_sva

bind spi_status_readback spi_status_readback_sva u_sva (
  .clk, .arst_n, .sclk, .cs_n, .so, .so_oe, .supply_low_fault,
  .supply_high_fault, .open_load_on_fault, .open_load_off_fault,
  .short_to_battery_fault, .thermal_fault, .severe_short_fault,
  .overcurrent_fault, .fault_status_pin_n, .duty_register,
  .switching_config, .fault_config, .overcurrent_profile, .global_config,
  .watchdog_toggle_bit
);

//--- dv/testbench.sv
`timescale 1ns/100ps
`define CHK(what, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", what, e, g); \
  end \
end

module testbench;
  import spi_status_pkg::*;
  logic                          clk, arst_n, sclk, cs_n, si, so, so_oe;
  logic                          normal_mode_flag, por_event;
  logic                          supply_low_fault, supply_high_fault;
  logic                          watchdog_active_flag, fault_status_pin_n;
  logic                          watchdog_toggle_bit;
  logic [N_OUT-1:0]              open_load_on_fault, open_load_off_fault;
  logic [N_OUT-1:0]              short_to_battery_fault, thermal_fault;
  logic [N_OUT-1:0]              severe_short_fault, overcurrent_fault;
  logic [N_OUT-1:0]              direct_inputs;
  logic [HEALTH_W-1:0]           device_health_flags;
  logic [N_OUT-1:0][DUTY_W-1:0]  duty_register;
  logic [N_OUT-1:0][SWCFG_W-1:0] switching_config;
  logic [N_OUT-1:0][FLTCFG_W-1:0] fault_config;
  logic [N_OUT-1:0][OCP_W-1:0]   overcurrent_profile;
  logic [GCR_W-1:0]              global_config;
  wire logic                     so_w;
  logic [31:0]                   rx;
  logic                          last_wd = 1'b0;
  int                            fail_count = 0;
  int                            tests_run = 0;

  // Serial output floats when not enabled
  assign so_w = so_oe ? so : 1'bz;

  // Product code value is arbitrary
  spi_status_readback #(.PRODUCT_CODE(3'h3)) u_dut (
    .clk, .arst_n, .sclk, .cs_n, .si, .so, .so_oe, .normal_mode_flag,
    .por_event, .supply_low_fault, .supply_high_fault, .open_load_on_fault,
    .open_load_off_fault, .short_to_battery_fault, .thermal_fault,
    .severe_short_fault, .overcurrent_fault, .device_health_flags,
    .direct_inputs, .watchdog_active_flag, .fault_status_pin_n,
    .duty_register, .switching_config, .fault_config,
    .overcurrent_profile, .global_config, .watchdog_toggle_bit
  );

  spi_master_model u_master (.clk, .so_w, .sclk, .cs_n, .si);

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Expected response word from the previous valid command
  function automatic logic [15:0] rsp(logic [4:0] sel, logic [8:0] pay);
    return {last_wd, sel, normal_mode_flag, pay};
  endfunction : rsp

  // One frame; first sixteen returned bits compared under a mask
  task automatic frame(input logic [31:0] tx, input int n,
                       input logic [15:0] exp, input logic [15:0] msk);
    logic [15:0] first;
    u_master.xfer(tx, n, rx);
    first = (n >= 16) ? 16'(rx >> (n - 16)) : 16'(rx << (16 - n));
    `CHK("response", exp & msk, first & msk)
    if (n % 16 == 0) last_wd = tx[15];
  endtask : frame

  task automatic t_reset;
    `CHK("so_oe idle", 1'b0, so_oe)
    `CHK("duty", 32'h0000_0000, duty_register)
    frame(32'h0000_0000, 16, 16'h0000, 16'hFEFF);
    $display("test reset done");
  endtask : t_reset

  task automatic t_readback;
    logic [15:0] w [8] = '{16'h0485, 16'h282B, 16'h4C5A, 16'h70C7,
                           16'h15A5, 16'h6411, 16'h6411, 16'h6411};
    logic [4:0]  s [8] = '{5'h01, 5'h0A, 5'h13, 5'h1C,
                           5'h05, 5'h07, 5'h0F, 5'h17};
    logic [8:0]  p [8] = '{9'h085, 9'h02B, 9'h05A, 9'h0C7,
                           9'h1A5, 9'h005, 9'h015, 9'h003};
    logic [4:0]  psel = 5'h00;
    logic [8:0]  ppay = 9'h000;
    @(negedge clk);
    normal_mode_flag = 1'b1;
    for (int i = 0; i < 8; i++) begin
      frame({16'h0000, 16'h8000 | w[i]}, 16, rsp(psel, ppay), 16'hFFFF);
      frame({27'h0, s[i]}, 16, rsp(psel, ppay), 16'hFFFF);
      psel = s[i];
      ppay = p[i];
    end
    frame(32'h0000_0000, 16, rsp(psel, ppay), 16'hFFFF);
    `CHK("global", 9'h1A5, global_config)
    `CHK("swcfg", 6'h2B, switching_config[1])
    `CHK("fltcfg", 7'h5A, fault_config[2])
    `CHK("ocp", 8'hC7, overcurrent_profile[3])
    $display("test readback done");
  endtask : t_readback

  task automatic t_fault;
    @(negedge clk);
    por_event = 1'b1;
    supply_low_fault = 1'b1;
    thermal_fault = 4'h1;
    open_load_off_fault = 4'h1;
    open_load_on_fault = 4'h2;
    @(negedge clk);
    por_event = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("fault pin", 1'b0, fault_status_pin_n)
    frame(32'h0000_0000, 16, rsp(5'h00, 9'h194), 16'hFFFF);
    frame(32'h0000_0000, 16, rsp(5'h00, 9'h094), 16'hFFFF);
    supply_low_fault = 1'b0;
    thermal_fault = 4'h0;
    open_load_off_fault = 4'h0;
    open_load_on_fault = 4'h0;
    repeat (3) @(negedge clk);
    `CHK("latched pin", 1'b0, fault_status_pin_n)
    frame(32'h0000_0405, 16, rsp(5'h00, 9'h094), 16'hFFFF);
    `CHK("released pin", 1'b1, fault_status_pin_n)
    $display("test fault done");
  endtask : t_fault

  task automatic t_length;
    frame(32'h0000_140F, 15, rsp(5'h00, 9'h000), 16'hFFFE);
    `CHK("global kept", 9'h1A5, global_config)
    `CHK("wd kept", last_wd, watchdog_toggle_bit)
    frame(32'h0000_0000, 16, rsp(5'h00, 9'h000), 16'hFFFF);
    frame(32'h3C96_14F0, 32, rsp(5'h00, 9'h000), 16'hFFFF);
    `CHK("echo", 16'h3C96, rx[15:0])
    `CHK("global new", 9'h0F0, global_config)
    $display("test length done");
  endtask : t_length

  task automatic t_rereset;
    frame(32'h0000_8001, 16, rsp(5'h00, 9'h000), 16'hFFFF);
    @(negedge clk);
    arst_n = 1'b0;
    normal_mode_flag = 1'b0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    last_wd = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("global reset", 9'h000, global_config)
    `CHK("wd reset", 1'b0, watchdog_toggle_bit)
    frame(32'h0000_0000, 16, 16'h0000, 16'hFEFF);
    $display("test rereset done");
  endtask : t_rereset

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    arst_n = 1'b0;
    {normal_mode_flag, por_event, supply_low_fault, supply_high_fault} = '0;
    {open_load_on_fault, open_load_off_fault, thermal_fault} = '0;
    {short_to_battery_fault, severe_short_fault, overcurrent_fault} = '0;
    device_health_flags = 3'h5;
    direct_inputs = 4'hA;
    watchdog_active_flag = 1'b1;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_reset;
    t_readback;
    t_fault;
    t_length;
    t_rereset;
    tally_and_finish;
  end

  // Watchdog, several times the expected run
  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule : testbench

//--- rtl/pin_sync3.sv
`timescale 1ns/100ps

// Three-stage pin synchroniser; output moves once stages two and three agree
module pin_sync3 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] stable
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  // Stage one feeds stage two only; agreement filter on two and three
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int b = 0; b < WIDTH; b++) begin
      if (st_q.s2[b] == st_q.s3[b]) begin
        st_d.out[b] = st_q.s3[b];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, out: RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign stable = st_q.out;

endmodule : pin_sync3

//--- rtl/spi_status_pkg.sv
package spi_status_pkg;

  // Word and field geometry of one serial frame
  localparam int WORD_W      = 16;
  localparam int N_OUT       = 4;
  localparam int PAYLOAD_W   = 9;
  localparam int SEL_W       = 5;
  localparam int CNT_W       = 4;
  localparam int CMD_WD_BIT  = 15;
  localparam int CMD_OUT_HI  = 14;
  localparam int CMD_OUT_LO  = 13;
  localparam int CMD_REG_HI  = 12;
  localparam int CMD_REG_LO  = 10;
  localparam int SEL_OUT_HI  = 4;
  localparam int SEL_OUT_LO  = 3;
  localparam int RSP_WD_BIT  = 15;
  localparam int RSP_SEL_HI  = 14;
  localparam int RSP_SEL_LO  = 10;
  localparam int RSP_NM_BIT  = 9;

  // Per-output and global register widths
  localparam int DUTY_W      = 8;
  localparam int SWCFG_W     = 6;
  localparam int FLTCFG_W    = 7;
  localparam int OCP_W       = 8;
  localparam int GCR_W       = 9;
  localparam int FAULT_W     = 8;
  localparam int HEALTH_W    = 3;
  localparam int PRODUCT_W   = 3;
  localparam int DUTY_ON_BIT = 7;

  // Register codes in the low three selector or address bits
  localparam logic [2:0] REG_FAULT_STATUS = 3'h0;
  localparam logic [2:0] REG_DUTY         = 3'h1;
  localparam logic [2:0] REG_SWCFG        = 3'h2;
  localparam logic [2:0] REG_FLTCFG       = 3'h3;
  localparam logic [2:0] REG_OCP          = 3'h4;
  localparam logic [2:0] REG_GLOBAL       = 3'h5;
  localparam logic [2:0] REG_DIAG         = 3'h7;

  // Upper selector bits that pick among global readbacks
  localparam logic [1:0] HI_GLOBAL        = 2'h0;
  localparam logic [1:0] HI_HEALTH        = 2'h0;
  localparam logic [1:0] HI_INPUT_WD      = 2'h1;
  localparam logic [1:0] HI_PRODUCT       = 2'h2;

  // Reset values
  localparam logic [SEL_W-1:0]     SEL_RST    = 5'h00;
  localparam logic [DUTY_W-1:0]    DUTY_RST   = 8'h00;
  localparam logic [SWCFG_W-1:0]   SWCFG_RST  = 6'h00;
  localparam logic [FLTCFG_W-1:0]  FLTCFG_RST = 7'h00;
  localparam logic [OCP_W-1:0]     OCP_RST    = 8'h00;
  localparam logic [GCR_W-1:0]     GCR_RST    = 9'h000;
  localparam logic [FAULT_W-1:0]   FAULT_RST  = 8'h00;
  localparam logic [WORD_W-1:0]    WORD_RST   = 16'h0000;
  localparam logic                 POR_RST    = 1'b1;

endpackage : spi_status_pkg

//--- rtl/spi_status_readback.sv
`timescale 1ns/100ps

// Contract
// - Chip select falling loads the selected 16-bit response into the shifter.
// - Response leaves MSB first while the command word shifts in.
// - First sixteen bits answer the previous transaction's selection.
// - Beyond sixteen bits, serial output repeats the received input bits.
// - Chip select rising latches data only for bit counts multiple of 16.
// - Valid end tri-states serial output and rearms fault capture.
// - Five-bit selector picks content; top two bits pick the output.
// - Selection persists until a new readback-select command arrives.
// - Invalid transaction leaves readback state untouched.
// - Response bit 15 echoes previous watchdog toggle bit.
// - Response bits 14..10 echo the five selector bits.
// - Response bit 9 is one in normal mode.
// - Bits 8..0 content chosen by selector low bits per code.
// - Fault readback bit 8 shows power-on flag, cleared only by read.
// - Fault readback bits 7..0 give selected output's fault flags.
// - Duty readback: bit 8 zero, on-command, seven-bit duty.
// - Switching readback: direct disable, slew select, delay count.
// - Fault-config readback returns bits 6..0 as programmed.
// - Overcurrent readback returns curves, override, level, mode.
// - After reset all returned bits read zero except bit 8.
// - Fault pin flags all faults; latched ones clear on switch-off.
// - Global-config readback returns the programmed global bits.
// - Health readback: clock range, calibration fail, prewarning.
// - Input readback: four direct inputs and watchdog enable flag.
module spi_status_readback #(
  // Product code value is arbitrary
  parameter logic [spi_status_pkg::PRODUCT_W-1:0] PRODUCT_CODE = 3'h2
) (
  input  wire logic                                     clk,
  input  wire logic                                     arst_n,
  input  wire logic                                     sclk,
  input  wire logic                                     cs_n,
  input  wire logic                                     si,
  output logic                                          so,
  output logic                                          so_oe,
  input  wire logic                                     normal_mode_flag,
  input  wire logic                                     por_event,
  input  wire logic                                     supply_low_fault,
  input  wire logic                                     supply_high_fault,
  input  wire logic [spi_status_pkg::N_OUT-1:0]         open_load_on_fault,
  input  wire logic [spi_status_pkg::N_OUT-1:0]         open_load_off_fault,
  input  wire logic [spi_status_pkg::N_OUT-1:0]         short_to_battery_fault,
  input  wire logic [spi_status_pkg::N_OUT-1:0]         thermal_fault,
  input  wire logic [spi_status_pkg::N_OUT-1:0]         severe_short_fault,
  input  wire logic [spi_status_pkg::N_OUT-1:0]         overcurrent_fault,
  input  wire logic [spi_status_pkg::HEALTH_W-1:0]      device_health_flags,
  input  wire logic [spi_status_pkg::N_OUT-1:0]         direct_inputs,
  input  wire logic                                     watchdog_active_flag,
  output logic                                          fault_status_pin_n,
  output logic [spi_status_pkg::N_OUT-1:0]
               [spi_status_pkg::DUTY_W-1:0]             duty_register,
  output logic [spi_status_pkg::N_OUT-1:0]
               [spi_status_pkg::SWCFG_W-1:0]            switching_config,
  output logic [spi_status_pkg::N_OUT-1:0]
               [spi_status_pkg::FLTCFG_W-1:0]           fault_config,
  output logic [spi_status_pkg::N_OUT-1:0]
               [spi_status_pkg::OCP_W-1:0]              overcurrent_profile,
  output logic [spi_status_pkg::GCR_W-1:0]              global_config,
  output logic                                          watchdog_toggle_bit
);

  import spi_status_pkg::*;

  typedef struct packed {
    logic                               cs_n_prev;
    logic                               sclk_prev;
    logic                               active;
    logic [WORD_W-1:0]                  shifter;
    logic                               so;
    logic [CNT_W-1:0]                   bit_cnt;
    logic                               got_word;
    logic [SEL_W-1:0]                   readback_selector;
    logic                               wd_echo;
    logic [N_OUT-1:0][DUTY_W-1:0]       duty;
    logic [N_OUT-1:0][SWCFG_W-1:0]      swcfg;
    logic [N_OUT-1:0][FLTCFG_W-1:0]     fltcfg;
    logic [N_OUT-1:0][OCP_W-1:0]        ocp;
    logic [GCR_W-1:0]                   global_configuration;
    logic [N_OUT-1:0][FAULT_W-1:0]      fault_register;
    logic                               por_flag;
    logic                               por_read;
    logic [N_OUT-1:0]                   latched;
    logic                               fs_n;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [2:0] pins_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       si_s;

  // Pin conditioning for the link clock, select and data
  pin_sync3 #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_pin_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    ({cs_n, sclk, si}),
    .stable (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s   = pins_s[0];

  // Live fault byte of one output, shared by capture and readback
  function automatic logic [FAULT_W-1:0] live_faults(input int unsigned o);
    live_faults = {supply_low_fault, supply_high_fault,
                   open_load_on_fault[o], open_load_off_fault[o],
                   short_to_battery_fault[o], thermal_fault[o],
                   severe_short_fault[o], overcurrent_fault[o]};
  endfunction : live_faults

  // Payload selected by the stored selector
  function automatic logic [PAYLOAD_W-1:0] payload(input state_t s);
    logic [1:0] o;
    logic [1:0] hi;
    o       = s.readback_selector[SEL_OUT_HI:SEL_OUT_LO];
    hi      = o;
    payload = '0;
    unique case (s.readback_selector[2:0])
      REG_FAULT_STATUS: payload = {s.por_flag,
                                   s.fault_register[o] | live_faults(o)};
      REG_DUTY:   payload = {1'b0, s.duty[o]};
      REG_SWCFG:  payload = {3'h0, s.swcfg[o]};
      REG_FLTCFG: payload = {2'h0, s.fltcfg[o]};
      REG_OCP:    payload = {1'b0, s.ocp[o]};
      REG_GLOBAL: begin
        if (hi == HI_GLOBAL) begin
          payload = s.global_configuration;
        end
      end
      REG_DIAG: begin
        if (hi == HI_HEALTH) begin
          payload = {6'h00, device_health_flags};
        end else if (hi == HI_INPUT_WD) begin
          payload = {4'h0, direct_inputs, watchdog_active_flag};
        end else if (hi == HI_PRODUCT) begin
          payload = {6'h00, PRODUCT_CODE};
        end
      end
      default: payload = '0;
    endcase
  endfunction : payload

  logic              cs_fall;
  logic              cs_rise;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              len_ok;
  logic [WORD_W-1:0] rx;
  logic [1:0]        w_out;
  logic [2:0]        w_reg;

  // Edge detection on the conditioned pins
  assign cs_fall   = st_q.cs_n_prev & ~cs_n_s;
  assign cs_rise   = ~st_q.cs_n_prev & cs_n_s;
  assign sclk_rise = st_q.active & ~st_q.sclk_prev & sclk_s;
  assign sclk_fall = st_q.active & st_q.sclk_prev & ~sclk_s;
  assign len_ok    = st_q.got_word & (st_q.bit_cnt == '0);
  assign rx        = st_q.shifter;
  assign w_out     = rx[CMD_OUT_HI:CMD_OUT_LO];
  assign w_reg     = rx[CMD_REG_HI:CMD_REG_LO];

  // Frame handling, register latch and fault bookkeeping
  always_comb begin
    st_d           = st_q;
    st_d.cs_n_prev = cs_n_s;
    st_d.sclk_prev = sclk_s;

    if (cs_fall) begin
      // Snapshot of the previous selection's answer
      st_d.shifter  = {st_q.wd_echo, st_q.readback_selector,
                       normal_mode_flag, payload(st_q)};
      st_d.so       = st_q.wd_echo;
      st_d.active   = 1'b1;
      st_d.bit_cnt  = '0;
      st_d.got_word = 1'b0;
      st_d.por_read = (st_q.readback_selector[2:0] == REG_FAULT_STATUS);
    end else if (cs_rise) begin
      st_d.active = 1'b0;
      if (len_ok) begin
        // Last complete word of the frame is the command
        st_d.wd_echo = rx[CMD_WD_BIT];
        unique case (w_reg)
          REG_FAULT_STATUS: begin
            st_d.readback_selector = rx[SEL_W-1:0];
          end
          REG_DUTY:   st_d.duty[w_out]   = rx[DUTY_W-1:0];
          REG_SWCFG:  st_d.swcfg[w_out]  = rx[SWCFG_W-1:0];
          REG_FLTCFG: st_d.fltcfg[w_out] = rx[FLTCFG_W-1:0];
          REG_OCP:    st_d.ocp[w_out]    = rx[OCP_W-1:0];
          REG_GLOBAL: begin
            if (w_out == HI_GLOBAL) begin
              st_d.global_configuration = rx[GCR_W-1:0];
            end
          end
          default: st_d.global_configuration = st_q.global_configuration;
        endcase
        if (st_q.por_read) begin
          st_d.por_flag = 1'b0;
        end
        st_d.fault_register = '0;
      end
      // An invalid frame changes nothing above
      st_d.por_read = 1'b0;
    end else if (sclk_rise) begin
      st_d.shifter = {st_q.shifter[WORD_W-2:0], si_s};
      st_d.bit_cnt = st_q.bit_cnt + 1'b1;
      if (st_q.bit_cnt == '1) begin
        st_d.got_word = 1'b1;
      end
    end else if (sclk_fall) begin
      st_d.so = st_q.shifter[WORD_W-1];
    end

    // Fault capture; new events win over the rearm
    for (int i = 0; i < N_OUT; i++) begin
      st_d.fault_register[i] = st_d.fault_register[i] | live_faults(i);
      if (thermal_fault[i] | severe_short_fault[i] | overcurrent_fault[i]) begin
        st_d.latched[i] = 1'b1;
      end else if (st_q.duty[i][DUTY_ON_BIT]
                   & ~st_d.duty[i][DUTY_ON_BIT]) begin
        st_d.latched[i] = 1'b0;
      end
    end
    if (por_event) begin
      st_d.por_flag = 1'b1;
    end

    // Fault pin, low while any fault present or latched
    st_d.fs_n = 1'b1;
    for (int i = 0; i < N_OUT; i++) begin
      if (st_d.latched[i] | (|live_faults(i))) begin
        st_d.fs_n = 1'b0;
      end
    end
  end

  // State register; everything clears on reset except por_flag, cs_n_prev and fs_n, which set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{cs_n_prev:         1'b1,
                sclk_prev:         1'b0,
                active:            1'b0,
                shifter:           WORD_RST,
                so:                1'b0,
                bit_cnt:           '0,
                got_word:          1'b0,
                readback_selector: SEL_RST,
                wd_echo:           1'b0,
                duty:              {N_OUT{DUTY_RST}},
                swcfg:             {N_OUT{SWCFG_RST}},
                fltcfg:            {N_OUT{FLTCFG_RST}},
                ocp:               {N_OUT{OCP_RST}},
                global_configuration:               GCR_RST,
                fault_register:    {N_OUT{FAULT_RST}},
                por_flag:          POR_RST,
                por_read:          1'b0,
                latched:           '0,
                fs_n:              1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign so                  = st_q.so;
  assign so_oe               = st_q.active;
  assign fault_status_pin_n  = st_q.fs_n;
  assign duty_register       = st_q.duty;
  assign switching_config    = st_q.swcfg;
  assign fault_config        = st_q.fltcfg;
  assign overcurrent_profile = st_q.ocp;
  assign global_config       = st_q.global_configuration;
  assign watchdog_toggle_bit = st_q.wd_echo;

endmodule : spi_status_readback
